// ### csf_framing.v
// serial framing of the codec: frame syncs, end-of-data strobes, data shift, gain select
//
// Summary of operation
// - rx frame sync falling edges are spaced one A/D conversion period, or one frame length if the period is shorter.
// - tx frame sync falling edges are spaced one D/A conversion period, or one frame length if the period is shorter.
// - word format: both end-of-data strobes go low once 16 bits shifted.
// - word format: word cycle is 20 shift clocks, 16 data plus 4 gap.
// - byte format: strobe high means first byte, low means second byte.
// - byte format: each byte cycle is 12 shift clocks including 4 gap.
// - gain bits equal give R, lo-only gives 2R, hi-only gives 4R.
`timescale 1ns/1ps
`include "csf_regs.vh"

module csf_framing #(
  parameter PW = 16
) (
  // system
  input wire clk_sys,
  input wire reset,
  // serial link pins
  input wire sclk,
  input wire dx,
  output reg dr,
  output reg rx_frame_sync,
  output reg tx_frame_sync,
  output reg rx_end_of_data,
  output reg tx_end_of_data,
  // configuration
  input wire byte_mode,
  input wire [PW-1:0] ad_period,
  input wire [PW-1:0] da_period,
  input wire gain_select_lo,
  input wire gain_select_hi,
  // converter side
  input wire [15:0] adc_word,
  output reg [15:0] dac_word,
  output reg dac_valid,
  output reg [1:0] feedback_sel
);

  // ******************************
  // helpers
  // ******************************

  // position lies inside a data phase
  function csf_active;
    input [PW-1:0] p;
    input bm;
    begin
      if (bm)
        csf_active = (p < `CSF_BYTE_BITS) ||
                     ((p >= `CSF_BYTE_CYCLE) && (p < `CSF_BYTE_CYCLE + `CSF_BYTE_BITS));
      else
        csf_active = (p < `CSF_WORD_BITS);
    end
  endfunction

  // bit index, msb first; second byte carries the low half
  function [3:0] csf_idx;
    input [PW-1:0] p;
    input bm;
    reg [4:0] t;
    begin
      t = 5'h00;
      if (bm && (p >= `CSF_BYTE_CYCLE))
        t = 5'h13 - p[4:0];
      else
        t = 5'h0f - p[4:0];
      csf_idx = t[3:0];
    end
  endfunction

  // ******************************
  // input synchronisers
  // ******************************

  reg sclk_s1_reg;
  reg sclk_s2_reg;
  reg sclk_s3_reg;
  reg dx_s1_reg;
  reg dx_s2_reg;
  wire sclk_rise;
  wire sclk_fall;

  // two flops before use, third for edge detect
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      dx_s1_reg <= 1'b0;
      dx_s2_reg <= 1'b0;
    end
    else
    begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      dx_s1_reg <= dx;
      dx_s2_reg <= dx_s1_reg;
    end
  end

  // edge strobes from the second and third stages
  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

  // ******************************
  // per-channel frame timing (0 = rx/A-D, 1 = tx/D-A)
  // ******************************

  wire [PW-1:0] frame_len;
  wire [PW-1:0] sync_end;
  wire [2*PW-1:0] period_in;
  wire [2*PW-1:0] pos_cur;
  wire [2*PW-1:0] pos_nxt;
  wire [1:0] fs_next;
  wire [1:0] eod_next;

  // frame length, end of sync low and both periods side by side
  assign frame_len = byte_mode ? {{(PW-5){1'b0}}, `CSF_BYTE_FRAME} :
                                 {{(PW-5){1'b0}}, `CSF_WORD_CYCLE};
  assign sync_end = byte_mode ? {{(PW-5){1'b0}}, `CSF_BYTE_CYCLE + `CSF_BYTE_BITS} :
                                {{(PW-5){1'b0}}, `CSF_WORD_BITS};
  assign period_in = {da_period, ad_period};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      reg [PW-1:0] pos_reg;
      wire [PW-1:0] period_eff;
      wire [PW-1:0] pos_next;

      // period never shorter than one frame
      assign period_eff = (period_in[ch*PW +: PW] < frame_len) ? frame_len :
                          period_in[ch*PW +: PW];
      // wrap at period end so sync falls once per period
      assign pos_next = (pos_reg >= period_eff - 1'b1) ? {PW{1'b0}} :
                        pos_reg + 1'b1;
      assign pos_cur[ch*PW +: PW] = pos_reg;
      assign pos_nxt[ch*PW +: PW] = pos_next;

      // position advances on each shift clock rise
      always @(posedge clk_sys or posedge reset)
      begin
        if (reset)
          pos_reg <= {PW{1'b1}};
        else if (sclk_rise)
          pos_reg <= pos_next;
      end

      // sync low through data; strobe level by format
      assign fs_next[ch] = ~(pos_next < sync_end);
      assign eod_next[ch] = byte_mode ?
                            ((pos_next < `CSF_BYTE_CYCLE) ||
                             (pos_next >= `CSF_BYTE_FRAME)) :
                            ~((pos_next >= `CSF_WORD_BITS) &&
                              (pos_next < `CSF_WORD_CYCLE));
    end
  endgenerate

  // ******************************
  // link outputs and data paths
  // ******************************

  reg [15:0] adc_hold_reg;
  reg [15:0] dac_shift_reg;
  wire [PW-1:0] rx_next;
  wire [PW-1:0] tx_cur;

  assign rx_next = pos_nxt[0 +: PW];
  assign tx_cur = pos_cur[PW +: PW];

  // pins change on shift clock rise
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rx_frame_sync <= 1'b1;
      tx_frame_sync <= 1'b1;
      rx_end_of_data <= 1'b1;
      tx_end_of_data <= 1'b1;
      dr <= 1'b0;
      adc_hold_reg <= 16'h0000;
    end
    else if (sclk_rise)
    begin
      rx_frame_sync <= fs_next[0];
      tx_frame_sync <= fs_next[1];
      rx_end_of_data <= eod_next[0];
      tx_end_of_data <= eod_next[1];
      if (rx_next == {PW{1'b0}})
      begin
        adc_hold_reg <= adc_word;
        dr <= adc_word[csf_idx(rx_next, byte_mode)];
      end
      else if (csf_active(rx_next, byte_mode))
        dr <= adc_hold_reg[csf_idx(rx_next, byte_mode)];
      else
        dr <= 1'b0;
    end
  end

  // receive word from host on shift clock fall
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      dac_shift_reg <= 16'h0000;
      dac_word <= 16'h0000;
      dac_valid <= 1'b0;
    end
    else
    begin
      dac_valid <= 1'b0;
      if (sclk_fall && csf_active(tx_cur, byte_mode))
        dac_shift_reg[csf_idx(tx_cur, byte_mode)] <= dx_s2_reg;
      if (sclk_rise && (tx_cur == sync_end))
      begin
        dac_word <= dac_shift_reg;
        dac_valid <= 1'b1;
      end
    end
  end

  // ******************************
  // gain select
  // ******************************

  // input amplifier feedback choice
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      feedback_sel <= `CSF_FB_R;
    else if (gain_select_lo == gain_select_hi)
      feedback_sel <= `CSF_FB_R;
    else if (gain_select_lo)
      feedback_sel <= `CSF_FB_2R;
    else
      feedback_sel <= `CSF_FB_4R;
  end

endmodule

// ### csf_framing_properties.sv
// concurrent checks on the codec serial framing ports
`timescale 1ns/1ps
module csf_framing_props (
  // system
  input wire clk_sys,
  input wire reset,
  // pins and setup
  input wire rx_frame_sync,
  input wire tx_frame_sync,
  input wire rx_end_of_data,
  input wire byte_mode,
  input wire gain_select_lo,
  input wire gain_select_hi,
  input wire [1:0] feedback_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // strobe gap and byte halves
  sequence s_gap;
    $fell(rx_end_of_data) ##[31:33] $rose(rx_end_of_data);
  endsequence
  sequence s_halves;
    ##[95:97] $fell(rx_end_of_data) ##[95:97] $rose(rx_end_of_data);
  endsequence
  property p_ad;
    $fell(rx_frame_sync) |-> ##[239:241] $fell(rx_frame_sync);
  endproperty
  property p_da;
    $fell(tx_frame_sync) |-> ##[319:321] $fell(tx_frame_sync);
  endproperty
  property p_eod;
    $rose(rx_frame_sync) && !byte_mode |-> s_gap;
  endproperty
  property p_word;
    $fell(rx_frame_sync) && !byte_mode |-> ##[127:129] $rose(rx_frame_sync);
  endproperty
  property p_first;
    $fell(rx_frame_sync) && byte_mode |-> rx_end_of_data;
  endproperty
  property p_byte;
    $fell(rx_frame_sync) && byte_mode |-> s_halves;
  endproperty
  property p_gain;
    1 |=> feedback_sel == (($past(gain_select_lo) == $past(gain_select_hi)) ? 2'h0 :
      ($past(gain_select_lo) ? 2'h1 : 2'h2));
  endproperty
  a_ad: assert property (p_ad) else $error("rx sync spacing");
  a_da: assert property (p_da) else $error("tx sync spacing");
  a_eod: assert property (p_eod) else $error("word strobe");
  a_word: assert property (p_word) else $error("word cycle");
  a_first: assert property (p_first) else $error("first byte");
  a_byte: assert property (p_byte) else $error("byte cycle");
  a_gain: assert property (p_gain) else $error("gain feedback");
endmodule

// ### csf_host_model.sv
// host serial port model: shift clock and transmit data
`timescale 1ns/1ps
module csf_host_model (
  // link pins
  output reg sclk,
  output reg dx,
  input wire tx_frame_sync,
  // host setup
  input wire byte_mode,
  input wire [15:0] word
);
  integer pos;
  reg fs_last;
  // free shift clock, phase apart from the system clock
  initial
  begin
    sclk = 1'b0;
    dx = 1'b0;
    pos = 99;
    fs_last = 1'b1;
    #7;
    forever #80 sclk = ~sclk;
  end
  // frame start puts the first bit up before the sampling fall;
  // each later rise moves to the next bit, toggling outside data
  always @(posedge sclk or negedge tx_frame_sync)
  begin
    if (fs_last && !tx_frame_sync)
    begin
      pos = 0;
      dx = word[15];
    end
    else
    begin
      pos = pos + 1;
      if (pos < 8 || (!byte_mode && pos < 16))
        dx = word[15-pos];
      else if (byte_mode && pos > 11 && pos < 20)
        dx = word[19-pos];
      else
        dx = ~dx;
    end
    fs_last = tx_frame_sync;
  end
endmodule

// ### csf_regs.vh
// constants of the codec serial framing block
`ifndef CSF_REGS_VH
`define CSF_REGS_VH
`define CSF_WORD_BITS 5'h10
`define CSF_BYTE_BITS 5'h08
`define CSF_WORD_CYCLE 5'h14
`define CSF_BYTE_CYCLE 5'h0c
`define CSF_SETUP_GAP 5'h04
`define CSF_BYTE_FRAME 5'h18
`define CSF_DEF_PERIOD 16'h0040
`define CSF_FB_R 2'h0
`define CSF_FB_2R 2'h1
`define CSF_FB_4R 2'h2
`endif

// ### tb.sv
// self-checking bench of the codec serial framing block
`timescale 1ns/1ps
module tb;
  reg clk_sys, reset, byte_mode, gain_select_lo, gain_select_hi;
  reg [15:0] adc_word, host_word, sh;
  wire sclk, dx, dr, rx_frame_sync, tx_frame_sync, rx_end_of_data, tx_end_of_data, dac_valid;
  wire [15:0] dac_word;
  wire [1:0] feedback_sel;
  integer fail_count, compares, i;
  // device and host
  csf_framing dut_u (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .dx(dx), .dr(dr),
    .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync),
    .rx_end_of_data(rx_end_of_data), .tx_end_of_data(tx_end_of_data),
    .byte_mode(byte_mode), .ad_period(16'h001e), .da_period(16'h0028),
    .gain_select_lo(gain_select_lo), .gain_select_hi(gain_select_hi), .adc_word(adc_word),
    .dac_word(dac_word), .dac_valid(dac_valid), .feedback_sel(feedback_sel));
  csf_host_model host_u (.sclk(sclk), .dx(dx), .tx_frame_sync(tx_frame_sync),
    .byte_mode(byte_mode), .word(host_word));
  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  function pick(input integer w);
    pick = (w == 0) ? rx_frame_sync : ((w == 1) ? tx_frame_sync : dac_valid);
  endfunction
  // bounded wait for a level
  task wait_lvl(input integer w, input v);
    integer n;
    begin
      n = 0;
      while (pick(w) !== v && n < 500)
      begin
        @(negedge clk_sys);
        n = n + 1;
      end
      if (pick(w) !== v)
      begin
        fail_count = fail_count + 1;
        finish_test;
      end
    end
  endtask
  // all four gain codes
  task t_gain;
    for (i = 0; i < 4; i = i + 1)
    begin
      {gain_select_hi, gain_select_lo} = i[1:0];
      repeat (2) @(negedge clk_sys);
      chk({14'h0000, feedback_sel}, (i == 3) ? 16'h0000 : i[15:0]);
    end
  endtask
  // word format both ways
  task t_word;
    begin
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      for (i = 0; i < 16; i = i + 1)
        @(posedge sclk) sh = {sh[14:0], dr};
      chk(sh, adc_word);
      @(posedge sclk);
      chk({15'h0000, rx_end_of_data}, 16'h0000);
      wait_lvl(1, 1'b1);
      wait_lvl(1, 1'b0);
      wait_lvl(2, 1'b1);
      chk(dac_word, host_word);
      chk({15'h0000, tx_end_of_data}, 16'h0000);
    end
  endtask
  // byte format both ways, switched between frames
  task t_byte;
    begin
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      repeat (64) @(negedge clk_sys);
      byte_mode = 1'b1;
      adc_word = 16'h5a3c;
      host_word = 16'hc35a;
      wait_lvl(0, 1'b0);
      chk({15'h0000, rx_end_of_data}, 16'h0001);
      for (i = 0; i < 20; i = i + 1)
        @(posedge sclk) if (i < 8 || i > 11) sh = {sh[14:0], dr};
      chk(sh, adc_word);
      chk({15'h0000, rx_end_of_data}, 16'h0000);
      wait_lvl(1, 1'b1);
      wait_lvl(1, 1'b0);
      chk({15'h0000, tx_end_of_data}, 16'h0001);
      wait_lvl(2, 1'b1);
      chk(dac_word, host_word);
    end
  endtask
  // reset, then scenarios
  initial
  begin
    {reset, byte_mode, gain_select_lo, gain_select_hi} = 4'h8;
    adc_word = 16'ha5c3;
    host_word = 16'h3c5a;
    sh = 16'h0000;
    fail_count = 0;
    compares = 0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    t_gain;
    t_word;
    t_byte;
    finish_test;
  end
endmodule
bind csf_framing csf_framing_props props_u (.clk_sys(clk_sys), .reset(reset),
  .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync),
  .rx_end_of_data(rx_end_of_data), .byte_mode(byte_mode), .gain_select_lo(gain_select_lo),
  .gain_select_hi(gain_select_hi), .feedback_sel(feedback_sel));
